/* File: spbc_top.sv */
// Serial port control, mode 0 shift engine, asynchronous framing and Timer 2 baud generator.
// Assumes clk is the oscillator, all inputs are synchronous and Timer 1 overflow arrives as a one-clock pulse.
// Contract
// [RULE_01] Mode bits pick shift mode at osc/12, one 8-bit asynchronous mode or two 9-bit asynchronous modes.
// [RULE_02] Mode 2 runs at osc/64, or osc/32 with the doubling bit set.
// [RULE_03] Modes 2 and 3 with filtering on drop frames whose ninth bit is 0.
// [RULE_04] Mode 1 with filtering on flags a frame only with a valid stop bit.
// [RULE_05] Software keeps filtering off in mode 0.
// [RULE_06] Control bit 4 enables reception when set, blocks it when clear.
// [RULE_07] Control bit 3 is sent as the ninth data bit in modes 2 and 3.
// [RULE_08] Control bit 2 captures ninth bit, or mode 1 stop bit; unused in mode 0.
// [RULE_09] Transmit-done sets after bit 8 in mode 0, else at stop start; software clears.
// [RULE_10] Receive-done sets after bit 8 in mode 0, else mid stop bit; software clears.
// [RULE_11] Timer 1 rate is overflow rate times two to the doubling bit over 32.
// [RULE_12] Software usually runs Timer 1 as 8-bit auto-reload, interrupt off.
// [RULE_13] Timer 2 select bits pick receive and transmit rate sources independently.
// [RULE_14] Timer 2 control selects port one; power control pair selects port two.
// [RULE_15] In baud mode each high byte rollover reloads both count bytes.
// [RULE_16] With Timer 2 as source the bit rate is its overflow rate over 16.
// [RULE_17] Timer 2 baud mode counts every state time, giving osc/(32*(65536-reload)).
// [RULE_18] Baud mode rollover sets no overflow flag and requests nothing.
// [RULE_19] Baud mode trigger falling edge sets the trigger flag but never reloads.
// [RULE_20] Software stops Timer 2 before touching its counts or reload pair.
// [RULE_21] Mode 0 moves 8 bits LSB first on data pin, shift clock on transmit pin.
// [RULE_22] Mode 0 write loads a marker, send starts one machine cycle later.
// [RULE_23] Mode 1 frame is start 0, eight data bits LSB first, stop 1.
// [RULE_24] Mode 0 receives when enabled and flag clear; else on start bit.
// [RULE_25] Receiver samples at 16x rate, majority of states 7, 8 and 9.
// [RULE_26] The chosen overflow is a one-clock pulse driving the divide-by-16 counter.
`timescale 1ns/1ps
`default_nettype none

module spbc_top
    import spbc_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    // Register port.
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Serial pins.
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd_out,
    // Timer sources and second port selects.
    input  wire logic       timer1_ovf,
    input  wire logic       ext_trigger_pin,
    output logic            port2_rx_t2_sel,
    output logic            port2_tx_t2_sel
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode.
    logic [7:0]  serial_control_status_q;
    logic [7:0]  serial_control_status_d;
    logic [7:0]  serial_data_buffer_q;
    logic [7:0]  timer2_control_q;
    logic [7:0]  timer2_control_d;
    logic [7:0]  power_control_q;
    logic [15:0] reload_capture_q;
    logic [15:0] t2_count_q;
    logic [7:0]  rdata_q;
    logic [3:0]  ph_q;
    logic [1:0]  pre_q;
    logic        t1_half_q;
    logic        state_time_q;
    logic        ext_prev_q;
    logic [1:0]  mode;
    logic        mc_end;
    logic        baud_mode;
    logic        t2_inc;
    logic        t2_ovf;
    logic        ext_fall;
    logic        m2_tick;
    logic        t1_tick;
    logic        tx_tick;
    logic        rx_tick;
    logic        wr_sdb;

    assign mode      = {serial_control_status_q[SCS_SM0], serial_control_status_q[SCS_SM1]}; // RULE_01
    assign mc_end    = (ph_q == PH_LAST);
    assign wr_sdb    = reg_wr && (reg_addr == ADDR_SDB);
    assign baud_mode = timer2_control_q[T2C_RCLK] | timer2_control_q[T2C_TX_RATE_SOURCE_SEL];
    assign port2_rx_t2_sel = power_control_q[PWR_RCK2]; // RULE_14
    assign port2_tx_t2_sel = power_control_q[PWR_TCK2]; // RULE_14
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Machine-cycle phases and rate prescalers.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ph_q         <= '0;
            pre_q        <= '0;
            t1_half_q    <= 1'b0;
            state_time_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ph_q         <= mc_end ? '0 : ph_q + 4'h1;
            pre_q        <= m2_tick ? '0 : pre_q + 2'h1;
            state_time_q <= ~state_time_q;
            if (timer1_ovf)
                t1_half_q <= ~t1_half_q;
        end
    end

    // A 16x tick is a one-clock pulse so the divide-by-16 counters can never double count.
    assign m2_tick = (pre_q == (power_control_q[PWR_BAUD_DOUBLE] ? PRE_M2_FAST : PRE_M2_SLOW)); // RULE_02
    assign t1_tick = timer1_ovf & (power_control_q[PWR_BAUD_DOUBLE] | t1_half_q); // RULE_11
    assign tx_tick = (mode == MODE_FIXED) ? m2_tick :
                     (timer2_control_q[T2C_TX_RATE_SOURCE_SEL] ? t2_ovf : t1_tick); // RULE_13 RULE_16 RULE_26
    assign rx_tick = (mode == MODE_FIXED) ? m2_tick :
                     (timer2_control_q[T2C_RCLK] ? t2_ovf : t1_tick); // RULE_13 RULE_16 RULE_26

    ////////////////////////////////////////////////////////////////////////////
    // Timer 2 steps only with T2C_CT clear: every state time as baud generator, otherwise every machine cycle.
    assign t2_inc   = timer2_control_q[T2C_RUN] & ~timer2_control_q[T2C_CT] &
                      (baud_mode ? state_time_q : mc_end); // RULE_17
    assign t2_ovf   = t2_inc && (t2_count_q == T2_TOP);
    assign ext_fall = ext_prev_q & ~ext_trigger_pin & timer2_control_q[T2C_EXEN];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            t2_count_q <= RST_WORD;
            ext_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ext_prev_q <= ext_trigger_pin;
            if (reg_wr && reg_addr == ADDR_T2L)
                t2_count_q[7:0] <= reg_wdata;
            else if (reg_wr && reg_addr == ADDR_T2H)
                t2_count_q[15:8] <= reg_wdata;
            else if (t2_ovf && (baud_mode || !timer2_control_q[T2C_CPRL]))
                t2_count_q <= reload_capture_q; // RULE_15
            else if (ext_fall && !baud_mode && !timer2_control_q[T2C_CPRL])
                t2_count_q <= reload_capture_q; // RULE_19
            else if (t2_inc)
                t2_count_q <= t2_count_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            reload_capture_q <= RST_WORD;
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == ADDR_RCL)
                reload_capture_q[7:0] <= reg_wdata;
            else if (reg_wr && reg_addr == ADDR_RCH)
                reload_capture_q[15:8] <= reg_wdata;
            else if (ext_fall && !baud_mode && timer2_control_q[T2C_CPRL])
                reload_capture_q <= t2_count_q;
        end
    end

    // Hardware sets win over a software clear in the same cycle.
    always_comb
    begin
        timer2_control_d = timer2_control_q;
        if (reg_wr && reg_addr == ADDR_T2C)
            timer2_control_d = reg_wdata;
        if (t2_ovf && !baud_mode)
            timer2_control_d[T2C_TF2] = 1'b1; // RULE_18
        if (ext_fall)
            timer2_control_d[T2C_EXF] = 1'b1; // RULE_19
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timer2_control_q <= RST_BYTE;
            power_control_q  <= RST_BYTE;
        end
        else if (clk_en)
        begin
            timer2_control_q <= timer2_control_d;
            if (reg_wr && reg_addr == ADDR_PWR)
                power_control_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter.
    logic [10:0] tx_sh_q;
    logic [3:0]  tx_cnt_q;
    logic [3:0]  tx_div_q;
    logic        tx_pend_q;
    logic        tx_arm_q;
    logic        tx_busy_q;
    logic        tx_line_q;
    logic        tx_roll;
    logic        ti_set;

    assign tx_roll = tx_tick && (tx_div_q == DIV16_LAST);
    assign ti_set  = (mode == MODE_SHIFT) ? (tx_busy_q && mc_end && tx_cnt_q == 4'h1)
                                          : (tx_busy_q && tx_roll && tx_cnt_q == 4'h1); // RULE_09

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            tx_div_q <= '0;
        else if (clk_en && tx_tick)
            tx_div_q <= tx_div_q + 4'h1; // RULE_26
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_sh_q   <= '1;
            tx_cnt_q  <= '0;
            tx_pend_q <= 1'b0;
            tx_arm_q  <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_line_q <= 1'b1;
        end
        else if (clk_en)
        begin
            if (wr_sdb)
            begin
                tx_pend_q <= 1'b1;
                tx_arm_q  <= 1'b0;
                if (mode == MODE_SHIFT)
                    tx_sh_q <= {2'b00, 1'b1, reg_wdata}; // RULE_22
                else if (mode == MODE_UART8)
                    tx_sh_q <= {2'b11, reg_wdata, 1'b0}; // RULE_23
                else
                    tx_sh_q <= {1'b1, serial_control_status_q[SCS_TB8], reg_wdata, 1'b0}; // RULE_07
            end
            else if (mode == MODE_SHIFT)
            begin
                // One whole machine cycle passes between the write and the first data bit.
                if (mc_end && tx_pend_q && !tx_arm_q)
                    tx_arm_q <= 1'b1; // RULE_22
                else if (mc_end && tx_arm_q)
                begin
                    tx_arm_q  <= 1'b0;
                    tx_pend_q <= 1'b0;
                    tx_busy_q <= 1'b1;
                    tx_cnt_q  <= BITS_M0; // RULE_21
                end
                else if (mc_end && tx_busy_q)
                begin
                    tx_sh_q  <= {1'b0, tx_sh_q[10:1]}; // RULE_21
                    tx_cnt_q <= tx_cnt_q - 4'h1;
                    if (tx_cnt_q == 4'h1)
                        tx_busy_q <= 1'b0;
                end
            end
            else if (tx_roll)
            begin
                // Bit times follow the divide-by-16 counter, not the write.
                if (tx_pend_q && !tx_busy_q)
                begin
                    tx_pend_q <= 1'b0;
                    tx_busy_q <= 1'b1;
                    tx_line_q <= tx_sh_q[0];
                    tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                    tx_cnt_q  <= ((mode == MODE_UART8) ? BITS_M1 : BITS_M23) - 4'h1; // RULE_23
                end
                else if (tx_busy_q && tx_cnt_q == 4'h0)
                    tx_busy_q <= 1'b0;
                else if (tx_busy_q)
                begin
                    tx_line_q <= tx_sh_q[0];
                    tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                    tx_cnt_q  <= tx_cnt_q - 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver.
    spbc_rx_t    rx_st_q;
    logic [8:0]  rx_sh_q;
    logic [3:0]  rx_cnt_q;
    logic [3:0]  rx_div_q;
    logic        smp_a_q;
    logic        smp_b_q;
    logic        rx_prev_q;
    logic        maj;
    logic        rx_end;
    logic        rx_accept;
    logic        ld;
    logic [7:0]  ld_data;
    logic        ld_ninth;
    logic        rx_start_bit;

    assign maj = (smp_a_q & smp_b_q) | (smp_a_q & rxd_in) | (smp_b_q & rxd_in); // RULE_25
    assign rx_start_bit = rx_tick && rx_prev_q && !rxd_in &&
                          serial_control_status_q[SCS_REN] && (mode != MODE_SHIFT); // RULE_06 RULE_24

    always_comb
    begin
        rx_end    = 1'b0;
        rx_accept = 1'b0;
        ld        = 1'b0;
        ld_data   = rx_sh_q[8:1];
        ld_ninth  = maj;
        unique case (rx_st_q)
            RX_IDLE:
                rx_end = 1'b0;
            RX_SHIFT:
            begin
                rx_end  = mc_end && (rx_cnt_q == 4'h1);
                ld      = rx_end; // RULE_10
                ld_data = {smp_a_q, rx_sh_q[8:2]};
                ld_ninth = serial_control_status_q[SCS_RB8]; // RULE_08
            end
            RX_ASYNC:
            begin
                if (mode == MODE_UART8)
                begin
                    rx_end    = rx_tick && rx_div_q == SMP_C && rx_cnt_q == BIT_STOP_M1;
                    rx_accept = !serial_control_status_q[SCS_SM2] || maj; // RULE_04
                end
                else
                begin
                    rx_end    = rx_tick && rx_div_q == SMP_C && rx_cnt_q == BIT_STOP_M23;
                    rx_accept = !serial_control_status_q[SCS_SM2] || rx_sh_q[8]; // RULE_03
                    ld_data   = rx_sh_q[7:0];
                    ld_ninth  = rx_sh_q[8]; // RULE_08
                end
                // A frame that finds the flag still set is lost by design.
                ld = rx_end && rx_accept && !serial_control_status_q[SCS_RI]; // RULE_10
            end
            default:
                rx_end = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_st_q   <= RX_IDLE;
            rx_sh_q   <= '1;
            rx_cnt_q  <= '0;
            rx_div_q  <= '0;
            smp_a_q   <= 1'b1;
            smp_b_q   <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else if (clk_en)
        begin
            if (rx_tick)
                rx_prev_q <= rxd_in;
            unique case (rx_st_q)
                RX_IDLE:
                begin
                    if (mode == MODE_SHIFT && mc_end && serial_control_status_q[SCS_REN] &&
                        !serial_control_status_q[SCS_RI]) // RULE_24 RULE_06
                    begin
                        rx_st_q  <= RX_SHIFT;
                        rx_sh_q  <= '1;
                        rx_cnt_q <= BITS_M0;
                    end
                    else if (rx_start_bit)
                    begin
                        rx_st_q  <= RX_ASYNC;
                        rx_div_q <= '0;
                        rx_cnt_q <= '0;
                        rx_sh_q  <= '1;
                    end
                end
                RX_SHIFT:
                begin
                    if (ph_q == PH_SAMPLE)
                        smp_a_q <= rxd_in; // RULE_21
                    if (mc_end)
                    begin
                        rx_sh_q  <= {smp_a_q, rx_sh_q[8:1]};
                        rx_cnt_q <= rx_cnt_q - 4'h1;
                        if (rx_end)
                            rx_st_q <= RX_IDLE;
                    end
                end
                RX_ASYNC:
                begin
                    if (rx_tick)
                    begin
                        rx_div_q <= rx_div_q + 4'h1; // RULE_26
                        if (rx_div_q == SMP_A)
                            smp_a_q <= rxd_in; // RULE_25
                        if (rx_div_q == SMP_B)
                            smp_b_q <= rxd_in; // RULE_25
                        if (rx_div_q == SMP_C)
                        begin
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q == 4'h0 && maj)
                                rx_st_q <= RX_IDLE;
                            else if (rx_end)
                                rx_st_q <= RX_IDLE;
                            else if (rx_cnt_q != 4'h0)
                                rx_sh_q <= {maj, rx_sh_q[8:1]};
                        end
                    end
                end
                default:
                    rx_st_q <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control/status register, receive buffer and read port.
    always_comb
    begin
        serial_control_status_d = serial_control_status_q;
        if (reg_wr && reg_addr == ADDR_SCS)
            serial_control_status_d = reg_wdata;
        if (ld)
            serial_control_status_d[SCS_RB8] = ld_ninth; // RULE_08
        if (ti_set)
            serial_control_status_d[SCS_TI] = 1'b1; // RULE_09
        if (ld)
            serial_control_status_d[SCS_RI] = 1'b1; // RULE_10
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_control_status_q <= RST_BYTE;
            serial_data_buffer_q    <= RST_BYTE;
            rdata_q                 <= RST_BYTE;
        end
        else if (clk_en)
        begin
            serial_control_status_q <= serial_control_status_d;
            if (ld)
                serial_data_buffer_q <= ld_data;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    ADDR_SCS: rdata_q <= serial_control_status_q;
                    ADDR_SDB: rdata_q <= serial_data_buffer_q;
                    ADDR_T2C: rdata_q <= timer2_control_q;
                    ADDR_PWR: rdata_q <= power_control_q;
                    ADDR_RCL: rdata_q <= reload_capture_q[7:0];
                    ADDR_RCH: rdata_q <= reload_capture_q[15:8];
                    ADDR_T2L: rdata_q <= t2_count_q[7:0];
                    ADDR_T2H: rdata_q <= t2_count_q[15:8];
                endcase
            end
            else
                rdata_q <= RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins: mode 0 drives data on the data pin and the shift clock on the transmit pin.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            txd_out <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe  <= 1'b0;
        end
        else if (clk_en)
        begin
            rxd_out <= tx_sh_q[0];
            rxd_oe  <= (mode == MODE_SHIFT) && tx_busy_q; // RULE_21
            if (mode == MODE_SHIFT)
                txd_out <= !((tx_busy_q || rx_st_q == RX_SHIFT) &&
                             ph_q >= PH_SCLK_LO && ph_q <= PH_SCLK_HI); // RULE_21
            else
                txd_out <= tx_line_q; // RULE_23
        end
    end

endmodule : spbc_top

`default_nettype wire

/* File: spbc_pkg.sv */
// Constants shared by the serial port and baud control block.
// Assumes the clock is the oscillator and one machine cycle is twelve clocks.
package spbc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port.
    localparam logic [2:0] ADDR_SCS = 3'h0;
    localparam logic [2:0] ADDR_SDB = 3'h1;
    localparam logic [2:0] ADDR_T2C = 3'h2;
    localparam logic [2:0] ADDR_PWR = 3'h3;
    localparam logic [2:0] ADDR_RCL = 3'h4;
    localparam logic [2:0] ADDR_RCH = 3'h5;
    localparam logic [2:0] ADDR_T2L = 3'h6;
    localparam logic [2:0] ADDR_T2H = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int SCS_SM0  = 7;
    localparam int SCS_SM1  = 6;
    localparam int SCS_SM2  = 5;
    localparam int SCS_REN  = 4;
    localparam int SCS_TB8  = 3;
    localparam int SCS_RB8  = 2;
    localparam int SCS_TI   = 1;
    localparam int SCS_RI   = 0;
    localparam int T2C_TF2  = 7;
    localparam int T2C_EXF  = 6;
    localparam int T2C_RCLK = 5;
    localparam int T2C_TX_RATE_SOURCE_SEL = 4;
    localparam int T2C_EXEN = 3;
    localparam int T2C_RUN  = 2;
    localparam int T2C_CT   = 1;
    localparam int T2C_CPRL = 0;
    localparam int PWR_BAUD_DOUBLE = 7;
    localparam int PWR_RCK2 = 5;
    localparam int PWR_TCK2 = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and mode codes.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] T2_TOP   = 16'hFFFF;
    localparam logic [1:0]  MODE_SHIFT = 2'h0;
    localparam logic [1:0]  MODE_UART8 = 2'h1;
    localparam logic [1:0]  MODE_FIXED = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: machine-cycle phases, prescalers, bit sampling, frame lengths.
    localparam logic [3:0] PH_LAST     = 4'hB;
    localparam logic [3:0] PH_SCLK_LO  = 4'h4;
    localparam logic [3:0] PH_SCLK_HI  = 4'h9;
    localparam logic [3:0] PH_SAMPLE   = 4'h9;
    localparam logic [3:0] PH_SHIFT    = 4'hB;
    localparam logic [1:0] PRE_M2_SLOW = 2'h3;
    localparam logic [1:0] PRE_M2_FAST = 2'h1;
    localparam logic [3:0] DIV16_LAST  = 4'hF;
    localparam logic [3:0] SMP_A       = 4'h7;
    localparam logic [3:0] SMP_B       = 4'h8;
    localparam logic [3:0] SMP_C       = 4'h9;
    localparam logic [3:0] BITS_M0     = 4'h8;
    localparam logic [3:0] BITS_M1     = 4'hA;
    localparam logic [3:0] BITS_M23    = 4'hB;
    localparam logic [3:0] BIT_STOP_M1 = 4'h9;
    localparam logic [3:0] BIT_STOP_M23 = 4'hA;

    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_ASYNC} spbc_rx_t;

endpackage : spbc_pkg

/* File: spbc_props.sv */
// Port assertions for the serial port block.
// Sees only spbc_top ports; bound in at the foot.
`timescale 1ns/1ps
`default_nettype none
module spbc_props
    import spbc_pkg::*;
(
    // Watched ports.
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rxd_oe,
    input wire logic       txd_out,
    input wire logic       port2_rx_t2_sel,
    input wire logic       port2_tx_t2_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] oe_cnt_q;
    // A counter, because a long repetition would slow the tools.
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            oe_cnt_q <= 8'h00;
        else
            oe_cnt_q <= rxd_oe ? oe_cnt_q + 8'h01 : 8'h00;
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_port2_sel: assert property (reg_wr && reg_addr == ADDR_PWR
        |=> {port2_rx_t2_sel, port2_tx_t2_sel} == $past(reg_wdata[5:4])) else $error("port2 select");
    a_sclk_low: assert property ($fell(txd_out) && rxd_oe |-> (!txd_out)[*6] ##1 txd_out)
        else $error("shift clock low phase");
    a_send_start: assert property ($rose(rxd_oe) |-> ##[3:5] $fell(txd_out))
        else $error("send start");
    a_send_len: assert property ($fell(rxd_oe) |-> oe_cnt_q >= 8'h5F && oe_cnt_q <= 8'h61)
        else $error("shift frame length");
    a_ctrl_back: assert property (reg_wr && reg_addr == ADDR_SCS ##1 reg_rd && reg_addr == ADDR_SCS
        |=> reg_rdata[7:3] == $past(reg_wdata[7:3], 2)) else $error("control readback");
    a_reload_back: assert property (reg_wr && reg_addr[2:1] == 2'h2 ##1 reg_rd && reg_addr == $past(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("reload readback");
    a_no_ovf_flag: assert property (reg_rd && reg_addr == ADDR_T2C
        |=> !(reg_rdata[T2C_RCLK] || reg_rdata[T2C_TX_RATE_SOURCE_SEL]) || !reg_rdata[T2C_TF2]) else $error("baud overflow flag");
    c_send: cover property ($fell(rxd_oe));
    c_sclk: cover property ($fell(txd_out) && rxd_oe);
    c_t2_read: cover property (reg_rd && reg_addr == ADDR_T2C);
endmodule // spbc_props
bind spbc_top spbc_props spbc_props_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rxd_oe, .txd_out, .port2_rx_t2_sel, .port2_tx_t2_sel);
`default_nettype wire

/* File: spbc_remote.sv */
// Remote device: takes shift-mode bytes, sends asynchronous frames.
// Assumes the line idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module spbc_remote (
    // Far-side pins.
    input  wire logic clk,
    input  wire logic rxd_out,
    input  wire logic rxd_oe,
    input  wire logic txd_out,
    output logic      line
);
    logic [7:0] cap_q = 8'h00;
    int         nbits = 0;
    initial line = 1'b1;
    always @(posedge txd_out)
        if (rxd_oe)
        begin
            cap_q = {rxd_out, cap_q[7:1]};
            nbits++;
        end
    task automatic send(input logic [10:0] frm, input int bt);
        for (int i = 0; i < 11; i++)
        begin
            line <= frm[i];
            repeat (bt) @(posedge clk);
        end
    endtask
endmodule // spbc_remote
`default_nettype wire

/* File: spbc_tb_top.sv */
// Self-checking bench for the serial port block.
// Assumes the remote model on the far side.
`timescale 1ns/1ps
`default_nettype none
module spbc_tb_top;
    import spbc_pkg::*;
    logic       clk, rstn, reg_wr, reg_rd, rxd_out, rxd_oe, txd_out, t1_ovf, ext, p2_rx, p2_tx, line;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, b;
    int         err_count, tests_run;
    spbc_top spbc_top_inst (.clk(clk), .rstn(rstn), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_in(rxd_oe ? rxd_out : line),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .timer1_ovf(t1_ovf), .ext_trigger_pin(ext),
        .port2_rx_t2_sel(p2_rx), .port2_tx_t2_sel(p2_tx));
    spbc_remote spbc_remote_inst (.clk(clk), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .line(line));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
        t1_ovf <= rstn && ($urandom % 4 == 0);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] v);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        cyc(1'b0, 1'b1, a, 8'h00);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & m, e & m);
        @(posedge clk);
    endtask
    task automatic test_done();
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #1000000;
        err_count++;
        test_done();
    end
    initial
    begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, t1_ovf, b, err_count, tests_run} = '0;
        ext = 1'b1;
        void'($urandom(75379));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(3'(i), RST_BYTE, 8'hFF);
        cyc(1'b1, 1'b0, ADDR_SCS, 8'hD8);
        rdc(ADDR_SCS, 8'hD8, 8'hF8);
        for (int i = 4; i < 6; i++)
        begin
            d = 8'($urandom);
            cyc(1'b1, 1'b0, 3'(i), d);
            rdc(3'(i), d, 8'hFF);
        end
        d = 8'($urandom);
        cyc(1'b1, 1'b0, ADDR_SCS, 8'h00);
        cyc(1'b1, 1'b0, ADDR_SDB, d);
        cyc(1'b0, 1'b0, ADDR_SCS, 8'h00);
        for (int n = 0; n < 200 && spbc_remote_inst.nbits < 8; n++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        chk(spbc_remote_inst.cap_q, d);
        rdc(ADDR_SCS, 8'h02, 8'hFF);
        for (int k = 0; k < 4; k++)
        begin
            d = 8'($urandom);
            cyc(1'b1, 1'b0, ADDR_PWR, {k[1], 7'h30});
            rdc(ADDR_PWR, {k[1], 7'h30}, 8'hB0);
            chk({6'h00, p2_rx, p2_tx}, 8'h03);
            cyc(1'b1, 1'b0, ADDR_SCS, 8'hB0);
            cyc(1'b1, 1'b0, ADDR_SDB, d);
            cyc(1'b0, 1'b0, ADDR_SCS, 8'h00);
            spbc_remote_inst.send({1'b1, k[0], d, 1'b0}, k[1] ? 32 : 64);
            repeat (99) @(posedge clk);
            rdc(ADDR_SCS, k[0] ? 8'hB7 : 8'hB2, 8'hFF);
            b = k[0] ? d : b;
            rdc(ADDR_SDB, b, 8'hFF);
        end
        for (int i = 4; i < 8; i++)
            cyc(1'b1, 1'b0, 3'(i), i[0] ? 8'hFF : 8'hF0);
        cyc(1'b1, 1'b0, ADDR_T2C, 8'h1C);
        cyc(1'b0, 1'b0, ADDR_T2C, 8'h00);
        repeat (100) @(posedge clk);
        ext <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(ADDR_T2C, 8'h5C, 8'hFF);
        test_done();
    end
endmodule // spbc_tb_top
`default_nettype wire
